// [prs_pkg.sv]
// constants, types and helpers for the power rail sequencer
// Notes on behaviour
// - each rail holds a mask of rails whose good inputs must all be high to start.
// - after start conditions hold, wait the rail's turn-on delay, then raise its enable.
// - time enable-to-good; if it passes the rail's ramp-up limit, flag a fault.
// - the ramp timer starts with the enable and stops when good is first seen.
// - a fault mask per rail names peer rails that also shut down on its fault.
// - example groups make any rail fault shut all four; first rail uses 0x0E.
// - during shutdown, keep a rail on until all rails in its off mask are down.
// - once shutdown starts and its off mask is met, wait turn-off delay, drop enable.
// - the primary input rail is monitored only, with no enable, delay or masks.
// - one shared 12-bit differential converter serves all voltage and current readings.
// - voltage readings use the single-ended zero to full scale range setting.
// - shunt current readings switch to the narrow range, then voltage range is restored.
package prs_pkg;
  localparam int N_RAILS = 4;
  localparam int DLY_W = 16;
  localparam int ADC_W = 12;
  localparam int CH_W = 3;
  localparam int CLK_FREQ_HZ = 250_000_000;
  localparam int TICK_PERIOD_MS = 1;
  localparam int CYCLES_PER_MS = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;
  localparam int ADC_SETTLE_CYCLES = 4;
  localparam logic [15:0] EX_FAULT_GROUP = 16'h7bde;
  localparam logic RANGE_VOLT = 1'b0;
  localparam logic RANGE_CURR = 1'b1;
  localparam logic [DLY_W-1:0] CNT_ZERO = '0;
  localparam logic [DLY_W-1:0] CNT_ONE = 16'h0001;

  typedef enum logic [2:0] {PRS_OFF, PRS_ON_WAIT, PRS_RAMP, PRS_ON, PRS_OFF_WAIT} prs_rail_st_t;
  typedef enum logic [1:0] {PRS_M_IDLE, PRS_M_SETTLE, PRS_M_CONV, PRS_M_WAIT} prs_meas_st_t;

  // true when every rail named in mask has its bit set in vec
  function automatic logic prs_mask_met(input logic [N_RAILS-1:0] mask, input logic [N_RAILS-1:0] vec);
    prs_mask_met = &(~mask | vec);
  endfunction : prs_mask_met
endpackage : prs_pkg

// [prs_sequencer.sv]
// power rail sequencer with shared measurement converter control
`timescale 1ns/1ps
`default_nettype none
module prs_sequencer #(
  parameter int N = prs_pkg::N_RAILS,
  parameter int TICK_CYCLES = prs_pkg::CYCLES_PER_MS,
  parameter logic [prs_pkg::N_RAILS*prs_pkg::N_RAILS-1:0] FAULT_GROUP = prs_pkg::EX_FAULT_GROUP
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic power_up_req,
  input wire logic fault_clear,
  input wire logic primary_good_pin,
  input wire logic [N-1:0] converter_good_input,
  input wire logic [N*N-1:0] up_prereq_mask,
  input wire logic [N*N-1:0] down_prereq_mask,
  input wire logic [N*prs_pkg::DLY_W-1:0] turn_on_delay,
  input wire logic [N*prs_pkg::DLY_W-1:0] ramp_up_limit,
  input wire logic [N*prs_pkg::DLY_W-1:0] turn_off_delay,
  output logic [N-1:0] rail_enable,
  output logic [N-1:0] rail_fault,
  output logic primary_good,
  input wire logic meas_req,
  input wire logic meas_current,
  input wire logic [prs_pkg::CH_W-1:0] meas_channel,
  output logic meas_busy,
  output logic meas_valid,
  output logic [prs_pkg::ADC_W-1:0] meas_data,
  output logic adc_start,
  output logic adc_range,
  output logic [prs_pkg::CH_W-1:0] adc_channel,
  input wire logic adc_done,
  input wire logic [prs_pkg::ADC_W-1:0] adc_data
);
  localparam int DW = prs_pkg::DLY_W;
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [3:0] SETTLE_LAST = 4'(prs_pkg::ADC_SETTLE_CYCLES - 1);

  // pin synchronisers; primary rail is watched only, never driven
  logic [N:0] good_meta_q, good_sync_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      good_meta_q <= '0;
      good_sync_q <= '0;
    end else begin
      good_meta_q <= {primary_good_pin, converter_good_input};
      good_sync_q <= good_meta_q;
    end
  end
  logic [N-1:0] good;
  assign good = good_sync_q[N-1:0];
  assign primary_good = good_sync_q[N];

  // millisecond timebase
  logic [TW-1:0] tick_cnt_q, tick_cnt_d;
  logic tick_q, tick_d;
  always_comb begin
    tick_d = (tick_cnt_q == TICK_LAST);
    tick_cnt_d = tick_d ? '0 : tick_cnt_q + TW'(1);
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
    end
  end

  // per-rail sequencing
  prs_pkg::prs_rail_st_t st_q [N];
  prs_pkg::prs_rail_st_t st_d [N];
  logic [DW-1:0] cnt_q [N];
  logic [DW-1:0] cnt_d [N];
  logic [N-1:0] en_q, en_d, fault_q, fault_d, up_ok, down_ok, shut;

  always_comb begin
    for (int r = 0; r < N; r++) begin
      down_ok[r] = prs_pkg::prs_mask_met(down_prereq_mask[r*N +: N], ~en_q & ~good);
      shut[r] = ~power_up_req | fault_q[r];
      for (int i = 0; i < N; i++) begin
        shut[r] = shut[r] | (fault_q[i] & FAULT_GROUP[i*N+r]);
      end
      // a standing group fault also keeps the peers from starting again
      up_ok[r] = ~shut[r] & primary_good & prs_pkg::prs_mask_met(up_prereq_mask[r*N +: N], good);
    end
    for (int r = 0; r < N; r++) begin
      st_d[r] = st_q[r];
      cnt_d[r] = cnt_q[r];
      en_d[r] = en_q[r];
      fault_d[r] = fault_q[r] & ~fault_clear;
      case (st_q[r])
        prs_pkg::PRS_OFF: begin
          if (up_ok[r]) begin
            st_d[r] = prs_pkg::PRS_ON_WAIT;
            cnt_d[r] = prs_pkg::CNT_ZERO;
          end
        end
        prs_pkg::PRS_ON_WAIT: begin
          if (!up_ok[r]) begin
            st_d[r] = prs_pkg::PRS_OFF;
          end else if (tick_q) begin
            if (cnt_q[r] >= turn_on_delay[r*DW +: DW]) begin
              st_d[r] = prs_pkg::PRS_RAMP;
              en_d[r] = 1'b1;
              cnt_d[r] = prs_pkg::CNT_ZERO;
            end else begin
              cnt_d[r] = cnt_q[r] + prs_pkg::CNT_ONE;
            end
          end
        end
        prs_pkg::PRS_RAMP: begin
          if (good[r]) begin
            st_d[r] = prs_pkg::PRS_ON;
          end else if (shut[r]) begin
            st_d[r] = prs_pkg::PRS_OFF_WAIT;
            cnt_d[r] = prs_pkg::CNT_ZERO;
          end else if (tick_q) begin
            if (cnt_q[r] >= ramp_up_limit[r*DW +: DW]) begin
              fault_d[r] = 1'b1;
              st_d[r] = prs_pkg::PRS_OFF_WAIT;
              cnt_d[r] = prs_pkg::CNT_ZERO;
            end else begin
              cnt_d[r] = cnt_q[r] + prs_pkg::CNT_ONE;
            end
          end
        end
        prs_pkg::PRS_ON: begin
          if (!good[r]) begin
            fault_d[r] = 1'b1;
          end
          if (shut[r] || !good[r]) begin
            st_d[r] = prs_pkg::PRS_OFF_WAIT;
            cnt_d[r] = prs_pkg::CNT_ZERO;
          end
        end
        prs_pkg::PRS_OFF_WAIT: begin
          if (down_ok[r] && tick_q) begin
            if (cnt_q[r] >= turn_off_delay[r*DW +: DW]) begin
              st_d[r] = prs_pkg::PRS_OFF;
              en_d[r] = 1'b0;
            end else begin
              cnt_d[r] = cnt_q[r] + prs_pkg::CNT_ONE;
            end
          end
        end
        default: begin
          st_d[r] = prs_pkg::PRS_OFF;
          en_d[r] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int r = 0; r < N; r++) begin
        st_q[r] <= prs_pkg::PRS_OFF;
        cnt_q[r] <= prs_pkg::CNT_ZERO;
      end
      en_q <= '0;
      fault_q <= '0;
    end else begin
      for (int r = 0; r < N; r++) begin
        st_q[r] <= st_d[r];
        cnt_q[r] <= cnt_d[r];
      end
      en_q <= en_d;
      fault_q <= fault_d;
    end
  end
  assign rail_enable = en_q;
  assign rail_fault = fault_q;

  // measurement control for the one shared converter
  prs_pkg::prs_meas_st_t m_st_q, m_st_d;
  logic range_q, range_d, start_q, start_d, valid_q, valid_d;
  logic [prs_pkg::CH_W-1:0] chan_q, chan_d;
  logic [prs_pkg::ADC_W-1:0] data_q, data_d;
  logic [3:0] settle_q, settle_d;
  always_comb begin
    m_st_d = m_st_q;
    range_d = range_q;
    chan_d = chan_q;
    data_d = data_q;
    settle_d = settle_q;
    start_d = 1'b0;
    valid_d = 1'b0;
    case (m_st_q)
      prs_pkg::PRS_M_IDLE: begin
        if (meas_req) begin
          range_d = meas_current ? prs_pkg::RANGE_CURR : prs_pkg::RANGE_VOLT;
          chan_d = meas_channel;
          settle_d = '0;
          m_st_d = prs_pkg::PRS_M_SETTLE;
        end
      end
      prs_pkg::PRS_M_SETTLE: begin
        settle_d = settle_q + 4'h1;
        if (settle_q == SETTLE_LAST) begin
          m_st_d = prs_pkg::PRS_M_CONV;
        end
      end
      prs_pkg::PRS_M_CONV: begin
        start_d = 1'b1;
        m_st_d = prs_pkg::PRS_M_WAIT;
      end
      prs_pkg::PRS_M_WAIT: begin
        if (adc_done) begin
          data_d = adc_data;
          valid_d = 1'b1;
          range_d = prs_pkg::RANGE_VOLT;
          m_st_d = prs_pkg::PRS_M_IDLE;
        end
      end
      default: begin
        m_st_d = prs_pkg::PRS_M_IDLE;
      end
    endcase
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      m_st_q <= prs_pkg::PRS_M_IDLE;
      range_q <= prs_pkg::RANGE_VOLT;
      chan_q <= '0;
      data_q <= '0;
      settle_q <= '0;
      start_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      m_st_q <= m_st_d;
      range_q <= range_d;
      chan_q <= chan_d;
      data_q <= data_d;
      settle_q <= settle_d;
      start_q <= start_d;
      valid_q <= valid_d;
    end
  end
  assign adc_start = start_q;
  assign adc_range = range_q;
  assign adc_channel = chan_q;
  assign meas_data = data_q;
  assign meas_valid = valid_q;
  assign meas_busy = (m_st_q != prs_pkg::PRS_M_IDLE);

  property p_tick_single;
    @(posedge sys_clk) disable iff (!reset_n) tick_q |=> !tick_q;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("tick longer than one cycle");

  property p_volt_restored;
    @(posedge sys_clk) disable iff (!reset_n) $rose(meas_valid) |-> adc_range == prs_pkg::RANGE_VOLT;
  endproperty
  a_volt_restored: assert property (p_volt_restored) else $error("voltage range not restored");

  property p_range_match;
    @(posedge sys_clk) disable iff (!reset_n) meas_req && !meas_busy && !meas_current
      |=> adc_range == prs_pkg::RANGE_VOLT [*5] ##1 adc_start;
  endproperty
  a_range_match: assert property (p_range_match) else $error("voltage reading not in voltage range");

  for (genvar g = 0; g < N; g++) begin : g_chk
    sequence s_enable_rise;
      !rail_enable[g] ##1 rail_enable[g];
    endsequence
    property p_en_needs_prereq;
      @(posedge sys_clk) disable iff (!reset_n) s_enable_rise |-> $past(up_ok[g]) && $past(tick_q);
    endproperty
    a_en_needs_prereq: assert property (p_en_needs_prereq) else $error("enable without start conditions");
    property p_ramp_from_zero;
      @(posedge sys_clk) disable iff (!reset_n) s_enable_rise |-> cnt_q[g] == prs_pkg::CNT_ZERO;
    endproperty
    a_ramp_from_zero: assert property (p_ramp_from_zero) else $error("ramp timer not cleared");
    property p_ramp_fault;
      @(posedge sys_clk) disable iff (!reset_n) st_q[g] == prs_pkg::PRS_RAMP && !good[g] && tick_q && !shut[g]
        && cnt_q[g] >= ramp_up_limit[g*DW +: DW] |=> rail_fault[g];
    endproperty
    a_ramp_fault: assert property (p_ramp_fault) else $error("ramp timeout without fault");
    property p_group_down;
      @(posedge sys_clk) disable iff (!reset_n) st_q[g] == prs_pkg::PRS_ON && shut[g]
        |=> st_q[g] == prs_pkg::PRS_OFF_WAIT;
    endproperty
    a_group_down: assert property (p_group_down) else $error("grouped rail not shut down");
    property p_off_order;
      @(posedge sys_clk) disable iff (!reset_n) $fell(rail_enable[g]) |-> $past(down_ok[g]);
    endproperty
    a_off_order: assert property (p_off_order) else $error("rail off before its off mask");
    property p_off_delay;
      @(posedge sys_clk) disable iff (!reset_n) $fell(rail_enable[g])
        |-> $past(tick_q) && $past(cnt_q[g]) >= turn_off_delay[g*DW +: DW];
    endproperty
    a_off_delay: assert property (p_off_delay) else $error("turn-off delay cut short");
    property p_abandon;
      @(posedge sys_clk) disable iff (!reset_n) st_q[g] == prs_pkg::PRS_ON_WAIT && !up_ok[g]
        |=> st_q[g] == prs_pkg::PRS_OFF && !rail_enable[g];
    endproperty
    a_abandon: assert property (p_abandon) else $error("pending enable not abandoned");
  end
endmodule : prs_sequencer
`default_nettype wire

// [prs_conv_model.sv]
// converter models: good follows enable after a ramp, pulled low while disabled
`timescale 1ns/1ps
`default_nettype none
module prs_conv_model #(
  parameter int N = 4
) (
  input wire logic sys_clk,
  input wire logic [N-1:0] enable,
  input wire logic [N-1:0] stuck_low,
  input wire logic [15:0] ramp_cycles,
  output var logic [N-1:0] good
);
  logic [15:0] cnt_q [N];
  always @(posedge sys_clk) begin
    for (int r = 0; r < N; r++) begin
      if (!enable[r]) begin
        cnt_q[r] <= 16'h0000;
        good[r] <= 1'b0;
      end else if (cnt_q[r] < ramp_cycles) begin
        cnt_q[r] <= cnt_q[r] + 16'h0001;
        good[r] <= 1'b0;
      end else begin
        good[r] <= !stuck_low[r];
      end
    end
  end
endmodule : prs_conv_model
`default_nettype wire

// [tb_power_rail_sequencer.sv]
// testbench for the power rail sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_power_rail_sequencer;
  localparam int N = prs_pkg::N_RAILS;
  localparam int T = 10;
  logic sys_clk = 1'b0, reset_n = 1'b0, power_up_req = 1'b0, fault_clear = 1'b0, primary_good_pin = 1'b1;
  logic [N-1:0] good, stuck = 4'h0, rail_enable, rail_fault;
  logic [N*N-1:0] up_mask = 16'h7310, down_mask = 16'h0008;
  logic [N*16-1:0] ton = {N{16'h0002}}, rlim = {N{16'h0014}}, toff = {N{16'h0001}};
  logic primary_good, meas_req = 1'b0, meas_current = 1'b0, meas_busy, meas_valid, adc_start, adc_range;
  logic adc_done = 1'b0;
  logic [2:0] meas_channel = 3'h0, adc_channel, ch;
  logic [11:0] meas_data, adc_data = 12'h000, adc_val = 12'h000;
  logic [3:0] adc_cnt = 4'h0;
  int err_count = 0, checks_done = 0;
  initial forever #2 sys_clk = ~sys_clk;
  prs_sequencer #(.N(N), .TICK_CYCLES(T)) DUT (.sys_clk(sys_clk), .reset_n(reset_n),
    .power_up_req(power_up_req), .fault_clear(fault_clear), .primary_good_pin(primary_good_pin),
    .converter_good_input(good), .up_prereq_mask(up_mask), .down_prereq_mask(down_mask),
    .turn_on_delay(ton), .ramp_up_limit(rlim), .turn_off_delay(toff), .rail_enable(rail_enable),
    .rail_fault(rail_fault), .primary_good(primary_good), .meas_req(meas_req), .meas_current(meas_current),
    .meas_channel(meas_channel), .meas_busy(meas_busy), .meas_valid(meas_valid), .meas_data(meas_data),
    .adc_start(adc_start), .adc_range(adc_range), .adc_channel(adc_channel), .adc_done(adc_done),
    .adc_data(adc_data));
  prs_conv_model #(.N(N)) conv (.sys_clk(sys_clk), .enable(rail_enable), .stuck_low(stuck),
    .ramp_cycles(16'h000f), .good(good));
  // converter answers three cycles after its start pulse; data lines toggle outside the answer
  always @(posedge sys_clk) begin
    adc_done <= adc_cnt == 4'h1;
    adc_data <= (adc_cnt == 4'h1) ? adc_val : ~adc_data;
    if (adc_start) begin
      adc_cnt <= 4'h3;
    end else if (adc_cnt != 4'h0) begin
      adc_cnt <= adc_cnt - 4'h1;
    end
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_in(input string what, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_in
  function automatic logic sig(input int sel, input int r);
    case (sel)
      0: sig = rail_enable[r];
      1: sig = rail_fault[r];
      2: sig = adc_start;
      default: sig = meas_valid;
    endcase
  endfunction : sig
  // counts edges until the selected output reaches v
  task automatic wait_sig(input int sel, input int r, input logic v, output int n);
    n = 0;
    while (n < 3000 && sig(sel, r) !== v) begin
      @(posedge sys_clk) #1;
      n++;
    end
    if (n >= 3000) begin
      err_count++;
      $display("wrong value wait %0d expected %h seen %h", sel, v, ~v);
      give_verdict();
    end
  endtask : wait_sig
  initial begin
    int n;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    #1 chk("enables", 16'h0, rail_enable);
    chk("faults", 16'h0, rail_fault);
    repeat (3) @(posedge sys_clk);
    #1 chk("primary_good", 16'h1, primary_good);
    @(posedge sys_clk) power_up_req <= 1'b1;
    wait_sig(0, 0, 1'b1, n);
    chk_in("rail0 on", 2 * T, 3 * T + 3, n);
    for (int r = 1; r < N; r++) begin
      wait_sig(0, r, 1'b1, n);
      chk("prereq", up_mask[r*N+:N], good & up_mask[r*N+:N]);
    end
    repeat (25) @(posedge sys_clk);
    #1 chk("no fault", 16'h0, rail_fault);
    @(posedge sys_clk) power_up_req <= 1'b0;
    wait_sig(0, 3, 1'b0, n);
    chk_in("rail3 off", T, 3 * T + 3, n);
    chk("rail0 held", 16'h1, rail_enable[0]);
    wait_sig(0, 0, 1'b0, n);
    chk_in("rail0 off", T, 3 * T + 6, n);
    @(posedge sys_clk) power_up_req <= 1'b1;
    repeat (15) @(posedge sys_clk);
    primary_good_pin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    primary_good_pin <= 1'b1;
    wait_sig(0, 0, 1'b1, n);
    chk_in("restart", 2 * T, 3 * T + 6, n);
    @(posedge sys_clk) power_up_req <= 1'b0;
    rlim <= {N{16'h0003}};
    stuck <= 4'h4;
    wait_sig(0, 0, 1'b0, n);
    repeat (4) @(posedge sys_clk);
    power_up_req <= 1'b1;
    wait_sig(0, 2, 1'b1, n);
    wait_sig(1, 2, 1'b1, n);
    chk_in("ramp fault", 3 * T, 4 * T + 4, n);
    chk("fault bits", 16'h4, rail_fault);
    for (int r = 0; r < N; r++) wait_sig(0, r, 1'b0, n);
    repeat (5 * T) @(posedge sys_clk);
    #1 chk("group down", 16'h0, rail_enable);
    @(posedge sys_clk) power_up_req <= 1'b0;
    stuck <= 4'h0;
    fault_clear <= 1'b1;
    @(posedge sys_clk) fault_clear <= 1'b0;
    @(posedge sys_clk) #1 chk("cleared", 16'h0, rail_fault);
    for (int i = 0; i < 2; i++) begin
      ch = i[0] ? 3'h2 : 3'h5;
      @(posedge sys_clk) meas_req <= 1'b1;
      meas_current <= i[0];
      meas_channel <= ch;
      adc_val <= i[0] ? 12'hc5e : 12'h3a5;
      @(posedge sys_clk) meas_req <= 1'b0;
      wait_sig(2, 0, 1'b1, n);
      chk_in("start delay", 5, 7, n);
      chk("busy", 16'h1, meas_busy);
      chk("range", {15'h0, i[0]}, adc_range);
      chk("channel", ch, adc_channel);
      wait_sig(3, 0, 1'b1, n);
      chk("data", adc_val, meas_data);
      chk("idle", 16'h0, meas_busy);
      chk("range back", prs_pkg::RANGE_VOLT, adc_range);
    end
    // reset in mid-run with a rail enabled clears outputs and counters
    @(posedge sys_clk) power_up_req <= 1'b1;
    wait_sig(0, 0, 1'b1, n);
    @(posedge sys_clk) reset_n <= 1'b0;
    #1 chk("reset enables", 16'h0, rail_enable);
    chk("reset data", 16'h0, meas_data);
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    #1 chk("released enables", 16'h0, rail_enable);
    chk("released primary", 16'h0, primary_good);
    give_verdict();
  end
endmodule : tb_power_rail_sequencer
`default_nettype wire
